// file: uds_ctrl.sv
// USB device control, status, interrupt mask and endpoint-0 handshake block
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Contract
// - Rising module enable loads staged endpoint configuration into the active copy.
// - Clearing module enable resets link state; flags stay for software to clear.
// - Clock gate bit enables the link logic; reset clears it.
// - Per-endpoint transfer-done enables raise the interrupt; endpoint 0 covers both directions.
// - Remote wake write drives K only when suspended and host allowed it.
// - Forced resume K lasts longer than 3 ms per request.
// - Configuration bit reads host-selected configuration, one or unconfigured.
// - Control-request flag sets on a valid error-free control request.
// - Frame-start flag sets on each detected start of frame.
// - Configuration-change flag sets when a new configuration is accepted.
// - Bus-reset flag sets on a valid bus reset state.
// - Bus reset pulses chip reset unless routing option selects an interrupt.
// - Wake-activity flag sets on bus activity while suspended.
// - Suspend flag sets on suspend state or 3 ms idle; enters suspend.
// - Status flags clear on writing zero, ignore ones, clear on reset.
// - Halt bit stalls IN and OUT tokens until next SETUP; write-only.
// - Mask bits let each set status flag raise the interrupt.
// - Bus-reset mask acts only when routing option is also set.
// - Endpoint-0 count reads last OUT size; written, sets next IN size.
// - Transmit-armed enables IN data; cleared by IN success, SETUP or software.
// - Transmit-done sets after IN success; NAKs further IN; cleared by zero.
// - Receive-full marks held OUT data; NAKs further OUT until cleared.
// - Receive-done sets when OUT or SETUP stored; NAKs OUT; zero clears.
module uds_ctrl #(
    parameter longint IDLE_LIMIT = uds_pkg::IDLE_CYCLES,
    parameter longint RESUME_LIMIT = uds_pkg::RESUME_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [uds_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [uds_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ev_ctrl_request,
    input wire logic ev_frame_start,
    input wire logic ev_cfg_accept,
    input wire logic cfg_selected,
    input wire logic ev_bus_reset,
    input wire logic ev_bus_activity,
    input wire logic ev_suspend_state,
    input wire logic bus_idle,
    input wire logic host_wake_enabled,
    input wire logic [3:0] ep_xfer_done_flags,
    input wire logic tok_in,
    input wire logic tok_out,
    input wire logic tok_setup,
    input wire logic in_acked,
    input wire logic pkt_stored,
    input wire logic [3:0] pkt_count,
    output logic cpu_irq,
    output logic mcu_reset_req,
    output logic k_drive,
    output logic ep0_resp_valid,
    output uds_pkg::uds_hs_t ep0_resp,
    output logic [3:0] ep0_tx_count,
    output logic [uds_pkg::CFG_W-1:0] ep_cfg_active,
    output logic link_clk_en,
    output logic module_active,
    output logic suspended
);
    import uds_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_have;
        logic w_have;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic module_enable;
        logic clock_gate;
        logic [4:0] xfer_irq_en;
        logic route_sel;
        logic [CFG_W-1:0] cfg_staged;
        logic [CFG_W-1:0] cfg_active;
        logic config_bit;
        logic [5:0] flags;
        logic [5:0] irq_en;
        logic halt;
        logic [3:0] rx_count;
        logic [3:0] tx_count;
        logic tx_armed;
        logic tx_done;
        logic rx_full;
        logic rx_done;
        uds_link_t lstate;
        logic [CNT_W-1:0] idle_cnt;
        logic [CNT_W-1:0] wake_cnt;
        logic k_drive;
        logic mcu_reset_req;
        logic cpu_irq;
        logic susp;
        logic resp_valid;
        uds_hs_t resp;
    } uds_state_t;

    localparam logic [CNT_W-1:0] IDLE_CNT_MAX = CNT_W'(IDLE_LIMIT);
    localparam logic [CNT_W-1:0] WAKE_CNT_INIT = CNT_W'(RESUME_LIMIT);

    uds_state_t state_reg;
    uds_state_t state_next;

    function automatic uds_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
        unique case (addr)
            OFS_LINK_CONTROL: reg_sel = SEL_CONTROL;
            OFS_LINK_STATUS: reg_sel = SEL_STATUS;
            OFS_LINK_IRQ_MASK: reg_sel = SEL_MASK;
            OFS_EP0_CTRL_STATUS: reg_sel = SEL_EP0;
            OFS_LINK_OPTION: reg_sel = SEL_OPTION;
            OFS_EP_CFG_STAGE: reg_sel = SEL_CFG;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction : reg_sel

    logic wr_fire;
    logic rd_fire;
    logic link_on;
    uds_sel_t wsel;
    logic [7:0] wbyte;
    logic wlane0;

    assign wr_fire = state_reg.aw_have && state_reg.w_have && !state_reg.bvalid;
    assign rd_fire = s_axi_arvalid && state_reg.arready;
    assign link_on = state_reg.module_enable && state_reg.clock_gate;
    assign wsel = reg_sel(state_reg.awaddr);
    assign wbyte = state_reg.wdata[7:0];
    assign wlane0 = state_reg.wstrb[0];

    always_comb
    begin
        logic [5:0] fl_term;
        logic [4:0] xf_term;
        logic [5:0] en_eff;
        state_next = state_reg;
        fl_term = '0;
        xf_term = '0;
        en_eff = '0;
        state_next.resp_valid = 1'b0;
        state_next.mcu_reset_req = 1'b0;

        // Write address and data latch independently
        if (s_axi_awvalid && state_reg.awready)
        begin
            state_next.aw_have = 1'b1;
            state_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_reg.wready)
        begin
            state_next.w_have = 1'b1;
            state_next.wdata = s_axi_wdata;
            state_next.wstrb = s_axi_wstrb;
        end
        if (state_reg.bvalid && s_axi_bready)
            state_next.bvalid = 1'b0;
        if (state_reg.rvalid && s_axi_rready)
            state_next.rvalid = 1'b0;

        if (wr_fire)
        begin
            state_next.aw_have = 1'b0;
            state_next.w_have = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (wlane0)
            begin
                unique case (wsel)
                    SEL_CONTROL:
                    begin
                        state_next.module_enable = wbyte[CTL_MODULE_ENABLE];
                        state_next.clock_gate = wbyte[CTL_CLOCK_GATE];
                        state_next.xfer_irq_en = wbyte[CTL_XFER_IE_HI:CTL_XFER_IE_LO];
                        if (wbyte[CTL_REMOTE_WAKE] && link_on && host_wake_enabled
                            && state_reg.lstate == LS_SUSPENDED)
                        begin
                            state_next.lstate = LS_WAKING;
                            state_next.wake_cnt = WAKE_CNT_INIT;
                        end
                    end
                    SEL_STATUS:
                        state_next.flags = state_reg.flags & wbyte[FLG_HI:FLG_LO];
                    SEL_MASK:
                    begin
                        state_next.irq_en = wbyte[FLG_HI:FLG_LO];
                        if (wbyte[MSK_HALT])
                            state_next.halt = 1'b1;
                    end
                    SEL_EP0:
                    begin
                        state_next.tx_count = wbyte[EP0_COUNT_HI:EP0_COUNT_LO];
                        state_next.tx_armed = wbyte[EP0_TX_ARMED];
                        state_next.tx_done = state_reg.tx_done & wbyte[EP0_TX_DONE];
                        state_next.rx_full = state_reg.rx_full & wbyte[EP0_RX_FULL];
                        state_next.rx_done = state_reg.rx_done & wbyte[EP0_RX_DONE];
                    end
                    SEL_OPTION:
                        state_next.route_sel = wbyte[OPT_ROUTE_SEL];
                    SEL_CFG:
                    begin
                    end
                    SEL_NONE:
                    begin
                    end
                endcase
            end
            // Staged configuration frozen while the module runs
            if (wsel == SEL_CFG && !state_reg.module_enable)
            begin
                for (int b = 0; b < 2; b++)
                begin
                    if (state_reg.wstrb[b])
                        state_next.cfg_staged[b*8 +: 8] = state_reg.wdata[b*8 +: 8];
                end
                state_next.cfg_staged[CFG_W-1:16] = state_reg.wstrb[2]
                    ? state_reg.wdata[CFG_W-1:16] : state_reg.cfg_staged[CFG_W-1:16];
            end
        end

        // Hardware events; placed after writes so a hardware set or clear beats a software write
        if (link_on)
        begin
            if (ev_ctrl_request)
                state_next.flags[FL_CTRL_REQUEST] = 1'b1;
            if (ev_frame_start)
                state_next.flags[FL_FRAME_START] = 1'b1;
            if (ev_cfg_accept)
            begin
                state_next.config_bit = cfg_selected;
                state_next.flags[FL_CFG_CHANGE] = 1'b1;
            end
            if (ev_bus_reset)
            begin
                state_next.flags[FL_BUS_RESET] = 1'b1;
                state_next.mcu_reset_req = !state_reg.route_sel;
                state_next.config_bit = 1'b0;
            end

            unique case (state_reg.lstate)
                LS_ACTIVE:
                begin
                    state_next.idle_cnt = bus_idle ? state_reg.idle_cnt + 1'b1 : '0;
                    if (ev_suspend_state || (bus_idle && state_reg.idle_cnt >= IDLE_CNT_MAX - 1'b1))
                    begin
                        state_next.flags[FL_SLEEP] = 1'b1;
                        state_next.lstate = LS_SUSPENDED;
                        state_next.idle_cnt = '0;
                    end
                end
                LS_SUSPENDED:
                begin
                    if (ev_bus_activity)
                    begin
                        state_next.flags[FL_WAKE] = 1'b1;
                        state_next.lstate = LS_ACTIVE;
                    end
                end
                LS_WAKING:
                begin
                    state_next.wake_cnt = state_reg.wake_cnt - 1'b1;
                    if (state_reg.wake_cnt <= 1)
                        state_next.lstate = LS_ACTIVE;
                end
            endcase

            // Endpoint-0 handshake
            if (tok_setup)
            begin
                state_next.resp_valid = 1'b1;
                state_next.resp = HS_ACK;
                state_next.halt = 1'b0;
                state_next.tx_armed = 1'b0;
            end
            else if (tok_in)
            begin
                state_next.resp_valid = 1'b1;
                if (state_reg.halt)
                    state_next.resp = HS_STALL;
                else if (!state_reg.tx_armed || state_reg.tx_done)
                    state_next.resp = HS_NAK;
                else
                    state_next.resp = HS_ACK;
            end
            else if (tok_out)
            begin
                state_next.resp_valid = 1'b1;
                if (state_reg.halt)
                    state_next.resp = HS_STALL;
                else if (state_reg.rx_full || state_reg.rx_done)
                    state_next.resp = HS_NAK;
                else
                    state_next.resp = HS_ACK;
            end
            if (in_acked)
            begin
                state_next.tx_armed = 1'b0;
                state_next.tx_done = 1'b1;
            end
            if (pkt_stored)
            begin
                state_next.rx_count = pkt_count;
                state_next.rx_full = 1'b1;
                state_next.rx_done = 1'b1;
            end
        end

        if (state_next.module_enable && !state_reg.module_enable)
            state_next.cfg_active = state_reg.cfg_staged;

        // Disable resets the link engine and the endpoint-0 handshake bits, not the status flags
        if (!state_next.module_enable)
        begin
            state_next.lstate = LS_ACTIVE;
            state_next.idle_cnt = '0;
            state_next.wake_cnt = '0;
            state_next.halt = 1'b0;
            state_next.tx_armed = 1'b0;
            state_next.tx_done = 1'b0;
            state_next.rx_full = 1'b0;
            state_next.rx_done = 1'b0;
            state_next.config_bit = 1'b0;
        end

        state_next.k_drive = (state_next.lstate == LS_WAKING);
        state_next.susp = (state_next.lstate != LS_ACTIVE);

        // Interrupt combine
        en_eff = state_next.irq_en;
        en_eff[FL_BUS_RESET] = state_next.irq_en[FL_BUS_RESET] && state_next.route_sel;
        fl_term = state_next.flags & en_eff;
        xf_term = state_next.xfer_irq_en
            & {ep_xfer_done_flags, state_next.tx_done | state_next.rx_done};
        state_next.cpu_irq = (|fl_term) || (|xf_term);

        // Read channel
        if (rd_fire)
        begin
            state_next.rvalid = 1'b1;
            state_next.rresp = RESP_OKAY;
            state_next.rdata = '0;
            unique case (reg_sel(s_axi_araddr))
                SEL_CONTROL:
                    state_next.rdata[7:0] = {state_reg.module_enable, state_reg.clock_gate,
                        state_reg.xfer_irq_en, 1'b0};
                SEL_STATUS:
                    state_next.rdata[7:0] = {state_reg.config_bit, state_reg.flags, 1'b0};
                SEL_MASK:
                    state_next.rdata[7:0] = {1'b0, state_reg.irq_en, 1'b0};
                SEL_EP0:
                    state_next.rdata[7:0] = {state_reg.rx_count, state_reg.tx_armed,
                        state_reg.tx_done, state_reg.rx_full, state_reg.rx_done};
                SEL_OPTION:
                    state_next.rdata[0] = state_reg.route_sel;
                SEL_CFG:
                    state_next.rdata[CFG_W-1:0] = state_reg.cfg_staged;
                SEL_NONE:
                    state_next.rresp = RESP_SLVERR;
            endcase
        end

        state_next.awready = !state_next.aw_have && !state_next.bvalid;
        state_next.wready = !state_next.w_have && !state_next.bvalid;
        state_next.arready = !state_next.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= '0;
            state_reg.lstate <= LS_ACTIVE;
            state_reg.resp <= HS_ACK;
        end
        else
            state_reg <= state_next;
    end

    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign s_axi_rvalid = state_reg.rvalid;
    assign cpu_irq = state_reg.cpu_irq;
    assign mcu_reset_req = state_reg.mcu_reset_req;
    assign k_drive = state_reg.k_drive;
    assign ep0_resp_valid = state_reg.resp_valid;
    assign ep0_resp = state_reg.resp;
    assign ep0_tx_count = state_reg.tx_count;
    assign ep_cfg_active = state_reg.cfg_active;
    assign link_clk_en = state_reg.clock_gate;
    assign module_active = state_reg.module_enable;
    assign suspended = state_reg.susp;

    // Checks
    sequence s_wake_kick;
        wr_fire && wlane0 && wsel == SEL_CONTROL && wbyte[CTL_REMOTE_WAKE]
            && wbyte[CTL_MODULE_ENABLE] && wbyte[CTL_CLOCK_GATE] && link_on
            && host_wake_enabled && state_reg.lstate == LS_SUSPENDED;
    endsequence

    property p_wake_k;
        @(posedge aclk) disable iff (!aresetn)
        s_wake_kick |=> k_drive ##1 k_drive;
    endproperty
    a_wake_k: assert property (p_wake_k) else $error("remote wake did not drive K");

    property p_k_from_suspend;
        @(posedge aclk) disable iff (!aresetn)
        $rose(k_drive) |-> $past(state_reg.lstate) == LS_SUSPENDED;
    endproperty
    a_k_from_suspend: assert property (p_k_from_suspend) else $error("K outside suspend");

    property p_sof_set;
        @(posedge aclk) disable iff (!aresetn)
        link_on && ev_frame_start ##1 state_reg.module_enable
            |-> state_reg.flags[FL_FRAME_START];
    endproperty
    a_sof_set: assert property (p_sof_set) else $error("frame start flag not set");

    property p_flag_clear;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wlane0 && wsel == SEL_STATUS && !wbyte[FLG_LO + FL_SLEEP]
            && !(link_on && (ev_suspend_state || bus_idle))
            |=> !state_reg.flags[FL_SLEEP];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("zero write kept flag");

    property p_halt_stall;
        @(posedge aclk) disable iff (!aresetn)
        link_on && tok_in && !tok_setup && state_reg.halt
            |=> ep0_resp_valid && ep0_resp == HS_STALL;
    endproperty
    a_halt_stall: assert property (p_halt_stall) else $error("halt did not stall");

    property p_in_nak;
        @(posedge aclk) disable iff (!aresetn)
        link_on && tok_in && !tok_setup && !state_reg.halt && !state_reg.tx_armed
            |=> ep0_resp_valid && ep0_resp == HS_NAK;
    endproperty
    a_in_nak: assert property (p_in_nak) else $error("unarmed IN not NAKed");

    property p_reset_route;
        @(posedge aclk) disable iff (!aresetn)
        link_on && ev_bus_reset |=> mcu_reset_req == !$past(state_reg.route_sel);
    endproperty
    a_reset_route: assert property (p_reset_route) else $error("bus reset routing wrong");

    property p_disable_clears;
        @(posedge aclk) disable iff (!aresetn)
        $fell(module_active) |-> !suspended && !state_reg.halt && !state_reg.tx_armed;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("disable left state");

    property p_irq_rst_gate;
        @(posedge aclk) disable iff (!aresetn)
        cpu_irq && !state_reg.route_sel && state_reg.xfer_irq_en == '0
            |-> |(state_reg.flags & state_reg.irq_en & 6'h3b);
    endproperty
    a_irq_rst_gate: assert property (p_irq_rst_gate) else $error("irq without cause");

    property p_bresp_time;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid;
    endproperty
    a_bresp_time: assert property (p_bresp_time) else $error("write answer late");
endmodule : uds_ctrl

// file: uds_host_model.sv
// Host-side model driving link events, tokens and bus levels
`timescale 1ns/1ps
module uds_host_model (
    input wire logic aclk,
    output logic [10:0] ev,
    output logic [2:0] lv,
    output logic [3:0] cnt
);
    initial
    begin
        ev = '0;
        lv = '0;
        cnt = 4'h5;
    end
    // One-cycle event or token, launched after an edge
    task automatic pulse(input int n);
        @(posedge aclk);
        ev[n] <= 1'b1;
        @(posedge aclk);
        ev[n] <= 1'b0;
    endtask : pulse
endmodule : uds_host_model

// file: uds_pkg.sv
// Constants and types for the USB device control, status and endpoint-0 block
package uds_pkg;
    localparam int ADDR_W = 8;
    localparam int CFG_W = 20;
    localparam int CNT_W = 18;
    // Register byte offsets
    localparam logic [7:0] OFS_LINK_CONTROL = 8'h00;
    localparam logic [7:0] OFS_LINK_STATUS = 8'h04;
    localparam logic [7:0] OFS_LINK_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_EP0_CTRL_STATUS = 8'h0c;
    localparam logic [7:0] OFS_LINK_OPTION = 8'h10;
    localparam logic [7:0] OFS_EP_CFG_STAGE = 8'h14;
    // link_control fields
    localparam int CTL_MODULE_ENABLE = 7;
    localparam int CTL_CLOCK_GATE = 6;
    localparam int CTL_XFER_IE_HI = 5;
    localparam int CTL_XFER_IE_LO = 1;
    localparam int CTL_REMOTE_WAKE = 0;
    // link_status / link_irq_mask fields
    localparam int STA_CONFIG = 7;
    localparam int MSK_HALT = 7;
    localparam int FLG_HI = 6;
    localparam int FLG_LO = 1;
    localparam int FL_SLEEP = 0;
    localparam int FL_WAKE = 1;
    localparam int FL_BUS_RESET = 2;
    localparam int FL_CFG_CHANGE = 3;
    localparam int FL_FRAME_START = 4;
    localparam int FL_CTRL_REQUEST = 5;
    // ep0_ctrl_status fields
    localparam int EP0_COUNT_HI = 7;
    localparam int EP0_COUNT_LO = 4;
    localparam int EP0_TX_ARMED = 3;
    localparam int EP0_TX_DONE = 2;
    localparam int EP0_RX_FULL = 1;
    localparam int EP0_RX_DONE = 0;
    // link_option fields
    localparam int OPT_ROUTE_SEL = 0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing
    localparam longint CLK_HZ = 50000000;
    localparam longint IDLE_TIME_MS = 3;
    localparam longint RESUME_TIME_MS = 3;
    localparam longint IDLE_CYCLES = (CLK_HZ * IDLE_TIME_MS) / 1000;
    // Resume must last longer than its figure, hence one extra cycle
    localparam longint RESUME_CYCLES = (CLK_HZ * RESUME_TIME_MS + 999) / 1000 + 1;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CONTROL,
        SEL_STATUS,
        SEL_MASK,
        SEL_EP0,
        SEL_OPTION,
        SEL_CFG
    } uds_sel_t;

    typedef enum logic [1:0] {
        LS_ACTIVE,
        LS_SUSPENDED,
        LS_WAKING
    } uds_link_t;

    typedef enum logic [1:0] {
        HS_ACK,
        HS_NAK,
        HS_STALL
    } uds_hs_t;
endpackage : uds_pkg

// file: usb_device_ctrl_status_ep0_tb.sv
// Self-checking bench for the control, status and endpoint-0 block
`timescale 1ns/1ps
module usb_device_ctrl_status_ep0_tb;
    import uds_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0] aw = '0, ar = '0;
    logic [31:0] wd = '0, rdat, d;
    logic awr, wrdy, bv, arr, rv, irq, rreq, kd, epv, mact, cken, susp;
    logic [1:0] bresp, rresp, r;
    logic [3:0] txc, cnt;
    logic [10:0] ev;
    logic [2:0] lv;
    uds_hs_t epr;
    int error_cnt = 0, n_tests = 0;
    logic [3:0] ws = 4'hf, xfd = '0;
    logic [19:0] cfga;
    always #10 aclk = ~aclk;
    uds_host_model uds_host_model_i (.aclk(aclk), .ev(ev), .lv(lv), .cnt(cnt));
    uds_ctrl #(.IDLE_LIMIT(20), .RESUME_LIMIT(21)) uds_ctrl_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .ev_ctrl_request(ev[0]), .ev_frame_start(ev[1]),
        .ev_cfg_accept(ev[2]), .cfg_selected(lv[2]), .ev_bus_reset(ev[3]),
        .ev_bus_activity(ev[4]), .ev_suspend_state(ev[5]), .bus_idle(lv[0]),
        .host_wake_enabled(lv[1]), .ep_xfer_done_flags(xfd), .tok_in(ev[6]),
        .tok_out(ev[7]), .tok_setup(ev[8]), .in_acked(ev[9]), .pkt_stored(ev[10]),
        .pkt_count(cnt), .cpu_irq(irq), .mcu_reset_req(rreq), .k_drive(kd),
        .ep0_resp_valid(epv), .ep0_resp(epr), .ep0_tx_count(txc), .ep_cfg_active(cfga),
        .link_clk_en(cken), .module_active(mact), .suspended(susp));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        aw <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
        fork
            begin do @(posedge aclk); while (!awr); awv <= 0; end
            begin do @(posedge aclk); while (!wrdy); wv <= 0; end
            begin do @(posedge aclk); while (!bv); br <= 0; r = bresp; end
        join
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ar <= a; arv <= 1; rr <= 1;
        do @(posedge aclk); while (!arr);
        arv <= 0;
        while (!rv) @(posedge aclk);
        rr <= 0; d = rdat; r = rresp;
        #1;
    endtask : rd
    task automatic tok(input int n, input uds_hs_t e);
        uds_host_model_i.pulse(n);
        #1;
        chk(epv, 1); chk(epr, e);
    endtask : tok
    task automatic t_flags;
        rd(OFS_LINK_CONTROL); chk(d, 0); chk(cken, 0);
        rd(OFS_LINK_STATUS); chk(d, 0);
        wr(OFS_EP_CFG_STAGE, 32'habcde);
        wr(OFS_LINK_CONTROL, 32'h40); wr(OFS_LINK_CONTROL, 32'hc0);
        chk(mact, 1); chk(cken, 1); chk(cfga, 32'habcde);
        uds_host_model_i.lv[2] <= 1;
        for (int i = 0; i < 3; i++) uds_host_model_i.pulse(i);
        rd(OFS_LINK_STATUS); chk(d, 32'hf0);
        wr(OFS_LINK_STATUS, 32'hff); rd(OFS_LINK_STATUS); chk(d, 32'hf0);
        wr(OFS_LINK_STATUS, 0); rd(OFS_LINK_STATUS); chk(d, 32'h80);
        wr(OFS_LINK_IRQ_MASK, 32'h20); uds_host_model_i.pulse(1);
        @(posedge aclk); #1 chk(irq, 1);
        wr(OFS_LINK_STATUS, 0); chk(irq, 0);
        wr(OFS_LINK_OPTION, 1); wr(OFS_LINK_IRQ_MASK, 32'h08); uds_host_model_i.pulse(3);
        @(posedge aclk); #1 chk(irq, 1); chk(rreq, 0);
        wr(OFS_LINK_STATUS, 0); wr(OFS_LINK_OPTION, 0); uds_host_model_i.pulse(3);
        #1 chk(rreq, 1); chk(irq, 0);
        wr(OFS_LINK_STATUS, 0); wr(OFS_LINK_IRQ_MASK, 0);
        rd(8'h20); chk(r, RESP_SLVERR); chk(d, 0);
        $display("t_flags done");
    endtask : t_flags
    task automatic t_ep0;
        tok(6, HS_NAK); wr(OFS_EP0_CTRL_STATUS, 32'h58); chk(txc, 4'h5);
        tok(6, HS_ACK); uds_host_model_i.pulse(9); rd(OFS_EP0_CTRL_STATUS);
        chk(d, 32'h04); tok(6, HS_NAK);
        wr(OFS_LINK_IRQ_MASK, 32'h80); tok(7, HS_STALL); tok(6, HS_STALL);
        tok(8, HS_ACK); tok(7, HS_ACK);
        uds_host_model_i.cnt <= 4'h9; uds_host_model_i.pulse(10); rd(OFS_EP0_CTRL_STATUS);
        chk(d[7:4], 4'h9); chk(d[1:0], 2'h3); tok(7, HS_NAK);
        wr(OFS_LINK_CONTROL, 32'hc2); chk(irq, 1);
        wr(OFS_LINK_CONTROL, 32'hc4); chk(irq, 0);
        xfd <= 4'h1; @(posedge aclk); #1 chk(irq, 1);
        xfd <= 4'h0; ws <= 4'he; wr(OFS_EP0_CTRL_STATUS, 0); ws <= 4'hf;
        rd(OFS_EP0_CTRL_STATUS); chk(d[2:0], 3'h7); wr(OFS_LINK_CONTROL, 32'hc0);
        $display("t_ep0 done");
    endtask : t_ep0
    task automatic t_sleep;
        uds_host_model_i.lv[0] <= 1; repeat (19) @(posedge aclk);
        #1 chk(susp, 0); @(posedge aclk); #1 chk(susp, 1);
        uds_host_model_i.lv[0] <= 0; uds_host_model_i.lv[1] <= 1;
        rd(OFS_LINK_STATUS); chk(d[1], 1);
        wr(OFS_LINK_CONTROL, 32'hc1); chk(kd, 1);
        repeat (19) @(posedge aclk); #1 chk(kd, 1);
        @(posedge aclk); #1 chk(kd, 0);
        wr(OFS_LINK_CONTROL, 32'hc1); chk(kd, 0);
        wr(OFS_LINK_STATUS, 0); uds_host_model_i.pulse(5); #1 chk(susp, 1);
        uds_host_model_i.pulse(4); rd(OFS_LINK_STATUS); chk(d[2:1], 2'h3);
        uds_host_model_i.pulse(5); #1 chk(susp, 1);
        wr(OFS_LINK_CONTROL, 0); chk(mact, 0); chk(susp, 0);
        $display("t_sleep done");
    endtask : t_sleep
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    initial
    begin
        #200000;
        error_cnt++;
        end_sim();
    end
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_flags(); t_ep0(); t_sleep();
        end_sim();
    end
endmodule : usb_device_ctrl_status_ep0_tb
